/* rctmr_pkg.sv */
// constants for the dual reload/capture timer
`default_nettype none
package rctmr_pkg;
   localparam int RCTMR_W = 16;
   localparam int RCTMR_NUM_INST = 2;
   // register offsets, instance stride is RCTMR_INST_STRIDE
   localparam logic [7:0] RCTMR_INST_STRIDE = 8'h10;
   localparam logic [3:0] RCTMR_CTRL_OFS = 4'h0;
   localparam logic [3:0] RCTMR_RELOAD_OFS = 4'h1;
   localparam logic [3:0] RCTMR_COUNT_OFS = 4'h2;
   localparam logic [3:0] RCTMR_STATUS_OFS = 4'h3;
   localparam logic [3:0] RCTMR_CLEAR_OFS = 4'h4;
   localparam logic [3:0] RCTMR_ENABLE_OFS = 4'h5;
   // control field positions
   localparam int RCTMR_CTRL_RUN = 0;
   localparam int RCTMR_CTRL_CAPMODE = 1;
   localparam int RCTMR_CTRL_COUNTER = 2;
   localparam int RCTMR_CTRL_TRIGEN = 3;
   localparam int RCTMR_CTRL_RISING = 4;
   localparam int RCTMR_CTRL_UPDOWN = 5;
   localparam int RCTMR_CTRL_W = 6;
   // status bit positions
   localparam int RCTMR_ST_RELOAD = 0;
   localparam int RCTMR_ST_CAPTURE = 1;
   localparam int RCTMR_ST_W = 2;
   localparam logic [15:0] RCTMR_ALL_ONES = 16'hFFFF;
   localparam logic [15:0] RCTMR_ZERO = 16'h0000;
   localparam logic [15:0] RCTMR_RESET_VAL = 16'h0000;
   localparam int RCTMR_TIMER_DIV = 12;
   localparam int RCTMR_COUNTER_GAP = 24;
endpackage : rctmr_pkg
`default_nettype wire

/* rctmr_timer.sv */
// dual 16-bit auto-reload / capture timer with register port and interrupt
//
// What this block does
// RULE_01 - 16-bit counter, auto-reload or capture mode
// RULE_02 - two identical instances, different register addresses
// RULE_03 - timer function ticks every twelve clocks
// RULE_04 - counter function counts input falling edges
// RULE_05 - counter events at most once per 24 clocks
// RULE_06 - up count from reload, overflow at ones
// RULE_07 - reload by overflow or selected trigger edge
// RULE_08 - reload value from writable 16-bit register
// RULE_09 - reload raises interrupt when up/down off
// RULE_10 - up/down direction follows trigger pin level
// RULE_11 - no reload interrupt with up/down on
// RULE_12 - down count from ones, underflow at reload
// RULE_13 - underflow reloads all-ones
// RULE_14 - capture mode counts up from zero, reloads zero
// RULE_15 - capture on selected trigger pin edge
// RULE_16 - capture copies count into reload register
// RULE_17 - capture mode interrupts on reload and capture
// RULE_18 - pins synchronised, edges from successive samples
// RULE_19 - count advances only while run set
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`default_nettype none

module rctmr_unit
   import rctmr_pkg::*;
#(
   parameter int W = RCTMR_W
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic count_input_pin,
   input wire logic ext_trigger_pin,
   input wire logic wr,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata_nxt,
   output logic irq_r
);
   logic [RCTMR_CTRL_W-1:0] ctrl_r;
   logic [W-1:0] reload_capture_value;
   logic [W-1:0] timer_count_value; // RULE_01
   logic [RCTMR_ST_W-1:0] status_r;
   logic [RCTMR_ST_W-1:0] enable_r;
   logic [2:0] cin_sync_r;
   logic [2:0] trg_sync_r;
   logic [3:0] div_r;
   logic [4:0] gap_r;
   logic tick;
   logic cin_fall;
   logic trg_edge;
   logic up_dn_mode;
   logic going_down;
   logic wrap;
   logic reload_ev;
   logic capture_ev;
   logic [RCTMR_ST_W-1:0] set_bits;
   logic run;

   assign run = ctrl_r[RCTMR_CTRL_RUN];

   // three-stage synchronisers; only stages 2 and 3 (bits 1 and 2) feed edge detection
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cin_sync_r <= 3'h7;
         trg_sync_r <= 3'h7;
      end
      else if (ce)
      begin
         cin_sync_r <= {cin_sync_r[1:0], count_input_pin}; // RULE_18
         trg_sync_r <= {trg_sync_r[1:0], ext_trigger_pin}; // RULE_18
      end
   end

   assign cin_fall = cin_sync_r[2] & ~cin_sync_r[1]; // RULE_04
   assign trg_edge = ctrl_r[RCTMR_CTRL_RISING] ? (~trg_sync_r[2] & trg_sync_r[1])
                                               : (trg_sync_r[2] & ~trg_sync_r[1]); // RULE_15

   // prescale counter for timer function, hold-off counter for counter function
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_r <= 4'h0;
         gap_r <= 5'h00;
      end
      else if (ce)
      begin
         if (!run || ctrl_r[RCTMR_CTRL_COUNTER])
            div_r <= 4'h0;
         else if (div_r == 4'(RCTMR_TIMER_DIV - 1))
            div_r <= 4'h0; // RULE_03
         else
            div_r <= div_r + 4'h1;
         if (gap_r != 5'h00)
            gap_r <= gap_r - 5'h01;
         else if (run && ctrl_r[RCTMR_CTRL_COUNTER] && cin_fall)
            gap_r <= 5'(RCTMR_COUNTER_GAP - 1); // RULE_05
      end
   end

   always_comb
   begin
      if (!run)
         tick = 1'b0; // RULE_19
      else if (ctrl_r[RCTMR_CTRL_COUNTER])
         tick = cin_fall && (gap_r == 5'h00); // RULE_04 RULE_05
      else
         tick = (div_r == 4'(RCTMR_TIMER_DIV - 1)); // RULE_03
   end

   assign up_dn_mode = ~ctrl_r[RCTMR_CTRL_CAPMODE] & ctrl_r[RCTMR_CTRL_UPDOWN];
   assign going_down = up_dn_mode & ~trg_sync_r[2]; // RULE_10
   assign wrap = going_down ? (timer_count_value == reload_capture_value) // RULE_12
                            : (timer_count_value == RCTMR_ALL_ONES); // RULE_06
   assign capture_ev = ctrl_r[RCTMR_CTRL_CAPMODE] & trg_edge; // RULE_15

   always_comb
   begin
      reload_ev = tick & wrap; // RULE_06 RULE_13
      if (!ctrl_r[RCTMR_CTRL_CAPMODE] && !up_dn_mode && ctrl_r[RCTMR_CTRL_TRIGEN] && trg_edge)
         reload_ev = 1'b1; // RULE_07
   end

   // count register: software write has priority, then reload, then increment or decrement
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         timer_count_value <= RCTMR_RESET_VAL;
      else if (ce)
      begin
         if (wr && addr == RCTMR_COUNT_OFS)
            timer_count_value <= wdata;
         else if (reload_ev)
         begin
            if (ctrl_r[RCTMR_CTRL_CAPMODE])
               timer_count_value <= RCTMR_ZERO; // RULE_14
            else if (going_down)
               timer_count_value <= RCTMR_ALL_ONES; // RULE_13
            else
               timer_count_value <= reload_capture_value; // RULE_06 RULE_08
         end
         else if (tick)
            timer_count_value <= going_down ? timer_count_value - 16'h0001
                                            : timer_count_value + 16'h0001; // RULE_10 RULE_14
      end
   end

   // reload/capture register; capture wins over a simultaneous software write
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reload_capture_value <= RCTMR_RESET_VAL;
      else if (ce)
      begin
         if (capture_ev)
            reload_capture_value <= timer_count_value; // RULE_16
         else if (wr && addr == RCTMR_RELOAD_OFS)
            reload_capture_value <= wdata; // RULE_08
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r <= '0;
         enable_r <= '0;
      end
      else if (ce && wr)
      begin
         if (addr == RCTMR_CTRL_OFS)
            ctrl_r <= wdata[RCTMR_CTRL_W-1:0];
         if (addr == RCTMR_ENABLE_OFS)
            enable_r <= wdata[RCTMR_ST_W-1:0];
      end
   end

   always_comb
   begin
      set_bits = '0;
      set_bits[RCTMR_ST_RELOAD] = reload_ev & ~up_dn_mode; // RULE_09 RULE_11 RULE_17
      set_bits[RCTMR_ST_CAPTURE] = capture_ev; // RULE_17
   end

   // sticky status: a new event beats a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         status_r <= '0;
      else if (ce)
      begin
         if (wr && addr == RCTMR_CLEAR_OFS)
            status_r <= (status_r & ~wdata[RCTMR_ST_W-1:0]) | set_bits;
         else
            status_r <= status_r | set_bits;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_r <= 1'b0;
      else if (ce)
         irq_r <= |(((status_r | set_bits) & ~((wr && addr == RCTMR_CLEAR_OFS) ?
                    wdata[RCTMR_ST_W-1:0] & ~set_bits : '0)) & enable_r);
   end

   always_comb
   begin
      unique case (addr)
         RCTMR_CTRL_OFS: rdata_nxt = 16'(ctrl_r);
         RCTMR_RELOAD_OFS: rdata_nxt = reload_capture_value;
         RCTMR_COUNT_OFS: rdata_nxt = timer_count_value;
         RCTMR_STATUS_OFS: rdata_nxt = 16'(status_r);
         RCTMR_ENABLE_OFS: rdata_nxt = 16'(enable_r);
         default: rdata_nxt = 16'h0000;
      endcase
   end

   // independent tally of enabled timer-function clocks since the last tick
   logic [4:0] tmr_gap_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tmr_gap_r <= 5'h00;
      else if (ce)
      begin
         if (!run || ctrl_r[RCTMR_CTRL_COUNTER] || tick)
            tmr_gap_r <= 5'h00;
         else
            tmr_gap_r <= tmr_gap_r + 5'h01;
      end
   end

   chk_capture_copy: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
      ce && capture_ev |=> reload_capture_value == $past(timer_count_value))
      else $error("capture did not copy count");
   chk_run_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE_19
      ce && !run && !(wr && addr == RCTMR_COUNT_OFS) && !reload_ev |=> $stable(timer_count_value))
      else $error("count moved while stopped");
   chk_timer_div: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
      ce && run && !ctrl_r[RCTMR_CTRL_COUNTER]
      |-> tick == (tmr_gap_r == 5'(RCTMR_TIMER_DIV - 1)))
      else $error("timer tick not at twelfth clock");
   chk_counter_gap: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
      ce && tick && ctrl_r[RCTMR_CTRL_COUNTER] |=> gap_r == 5'(RCTMR_COUNTER_GAP - 1))
      else $error("counter hold-off not started");
   chk_updown_noirq: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
      ce && up_dn_mode |=> !$rose(status_r[RCTMR_ST_RELOAD]))
      else $error("reload flag in up/down mode");
   chk_down_reload: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
      ce && tick && going_down && wrap && !wr |=> timer_count_value == RCTMR_ALL_ONES)
      else $error("underflow did not reload ones");
   chk_cap_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
      ce && ctrl_r[RCTMR_CTRL_CAPMODE] && tick && timer_count_value == RCTMR_ALL_ONES && !wr
      |=> timer_count_value == RCTMR_ZERO)
      else $error("capture mode overflow not zero");
   chk_up_reload: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
      ce && !ctrl_r[RCTMR_CTRL_CAPMODE] && !going_down && tick && wrap && !wr
      |=> timer_count_value == $past(reload_capture_value))
      else $error("overflow did not load reload value");
   chk_reload_flag: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
      ce && reload_ev && !up_dn_mode |=> status_r[RCTMR_ST_RELOAD])
      else $error("reload flag not set");
   chk_trig_reload: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
      ce && !ctrl_r[RCTMR_CTRL_CAPMODE] && !up_dn_mode && ctrl_r[RCTMR_CTRL_TRIGEN] && trg_edge && !wr
      |=> timer_count_value == $past(reload_capture_value))
      else $error("trigger edge did not reload");
   chk_up_step: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
      ce && up_dn_mode && trg_sync_r[2] && tick && !wrap && !wr
      |=> timer_count_value == W'($past(timer_count_value) + W'(1)))
      else $error("up/down mode did not count up with pin high");
   chk_down_step: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
      ce && going_down && tick && !wrap && !wr
      |=> timer_count_value == W'($past(timer_count_value) - W'(1)))
      else $error("down count did not step down");
   chk_irq_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
      ce && |(status_r & enable_r) && !(wr && (addr == RCTMR_CLEAR_OFS || addr == RCTMR_ENABLE_OFS))
      |=> irq_r)
      else $error("interrupt low with enabled flag set");
   chk_no_capture: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
      ce && !ctrl_r[RCTMR_CTRL_CAPMODE] && !(wr && addr == RCTMR_RELOAD_OFS)
      |=> $stable(reload_capture_value))
      else $error("reload register moved outside capture");
   // a low clock enable must freeze the count, the status flags and the control register
   chk_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
      !ce |=> $stable(timer_count_value) && $stable(status_r) && $stable(ctrl_r))
      else $error("state moved with clock enable low");
   chk_status_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !(wr && addr == RCTMR_CLEAR_OFS) |=> (status_r & $past(status_r)) == $past(status_r))
      else $error("status flag dropped without clear");
endmodule : rctmr_unit

module rctmr_timer
   import rctmr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [RCTMR_NUM_INST-1:0] count_input_pin,
   input wire logic [RCTMR_NUM_INST-1:0] ext_trigger_pin,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic irq
);
   logic rst_meta_r;
   logic rst_sync_n;
   logic [15:0] unit_rdata [RCTMR_NUM_INST];
   logic [RCTMR_NUM_INST-1:0] unit_irq;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_n <= rst_meta_r;
      end
   end

   for (genvar i = 0; i < RCTMR_NUM_INST; i++)
   begin : g_unit
      rctmr_unit u_unit (
         .clk(ref_clk),
         .rst_n(rst_sync_n),
         .ce(clk_en),
         .count_input_pin(count_input_pin[i]),
         .ext_trigger_pin(ext_trigger_pin[i]),
         .wr(reg_wr && reg_addr[7:4] == 4'(i)), // RULE_02
         .addr(reg_addr[3:0]),
         .wdata(reg_wdata),
         .rdata_nxt(unit_rdata[i]),
         .irq_r(unit_irq[i])
      );
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         reg_rdata <= 16'h0000;
      else if (clk_en)
      begin
         if (reg_rd && reg_addr[7:4] < 4'(RCTMR_NUM_INST))
            reg_rdata <= unit_rdata[reg_addr[4]];
         else
            reg_rdata <= 16'h0000;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         irq <= 1'b0;
      else if (clk_en)
         irq <= |unit_irq;
   end
endmodule : rctmr_timer
`default_nettype wire

/* rctmr_timer_bench.sv */
// self-checking bench for the dual reload/capture timer
`default_nettype none
module rctmr_timer_bench
   import rctmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] c_run = 16'h0001 << RCTMR_CTRL_RUN;
   localparam logic [15:0] c_cap = 16'h0001 << RCTMR_CTRL_CAPMODE;
   localparam logic [15:0] c_cnt = 16'h0001 << RCTMR_CTRL_COUNTER;
   localparam logic [15:0] c_trg = 16'h0001 << RCTMR_CTRL_TRIGEN;
   localparam logic [15:0] c_ris = 16'h0001 << RCTMR_CTRL_RISING;
   localparam logic [15:0] c_ud = 16'h0001 << RCTMR_CTRL_UPDOWN;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] cnt_pin = 2'b11;
   logic [1:0] trg_pin = 2'b11;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic clk_en = 1'b1;
   logic [15:0] reg_rdata;
   logic irq;
   logic [15:0] rv;
   logic [15:0] dv;
   int mismatches = 0;
   int samples_checked = 0;

   always #12.5 ref_clk = ~ref_clk;

   rctmr_timer DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .count_input_pin(cnt_pin),
      .ext_trigger_pin(trg_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

   task automatic tally_and_finish();
      $display("checked %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   task automatic wr(input int i, input logic [3:0] o, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= {i[3:0], o};
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // data stands only in the cycle after the strobe; take it at the edge that closes that cycle
   task automatic rd(input int i, input logic [3:0] o);
      @(posedge ref_clk);
      reg_addr <= {i[3:0], o};
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      rv = reg_rdata;
   endtask : rd

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk16

   task automatic chk_irq(input logic exp, input string what);
      samples_checked++;
      if (irq !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: irq %s got %b", $time, what, irq);
      end
   endtask : chk_irq

   task automatic wait_st(input int i, input int b);
      for (int n = 0; n < 300; n++)
      begin
         rd(i, RCTMR_STATUS_OFS);
         if (rv[b] === 1'b1)
            return;
      end
      mismatches++;
      $display("mismatch at %0t: status bit %0d never set", $time, b);
      tally_and_finish();
   endtask : wait_st

   // two count samples exactly 120 enabled clocks apart, independent of prescaler phase;
   // frz clocks with the clock enable low are slipped in between and must not count
   task automatic meas(input int i, input int frz);
      logic [15:0] c0;
      rd(i, RCTMR_COUNT_OFS);
      c0 = rv;
      repeat (58) @(posedge ref_clk);
      if (frz > 0)
      begin
         clk_en <= 1'b0;
         repeat (frz) @(posedge ref_clk);
         clk_en <= 1'b1;
      end
      repeat (59) @(posedge ref_clk);
      rd(i, RCTMR_COUNT_OFS);
      dv = rv - c0;
   endtask : meas

   task automatic t_regs();
      rd(0, RCTMR_CTRL_OFS);
      chk16(rv, RCTMR_RESET_VAL, "ctrl reset");
      rd(1, RCTMR_RELOAD_OFS);
      chk16(rv, RCTMR_RESET_VAL, "reload reset");
      wr(2, RCTMR_RELOAD_OFS, 16'h5A5A);
      rd(2, RCTMR_RELOAD_OFS);
      chk16(rv, 16'h0000, "unmapped instance");
      wr(0, RCTMR_STATUS_OFS, 16'h0003);
      rd(0, RCTMR_STATUS_OFS);
      chk16(rv, 16'h0000, "status read-only");
      rd(0, 4'hF);
      chk16(rv, 16'h0000, "unmapped offset");
      chk_irq(1'b0, "after reset");
      $display("test regs done");
   endtask : t_regs

   task automatic t_timer();
      wr(0, RCTMR_RELOAD_OFS, 16'h1234);
      wr(0, RCTMR_COUNT_OFS, 16'hFFFE);
      wr(0, RCTMR_ENABLE_OFS, 16'h0003);
      wr(0, RCTMR_CTRL_OFS, c_run);
      wait_st(0, RCTMR_ST_RELOAD);
      chk_irq(1'b1, "reload event");
      rd(0, RCTMR_COUNT_OFS);
      chk16({rv[15:4], 4'h0}, 16'h1230, "count after overflow");
      meas(0, 0);
      chk16(dv, 16'(120 / RCTMR_TIMER_DIV), "timer rate");
      meas(0, 200);
      chk16(dv, 16'(120 / RCTMR_TIMER_DIV), "frozen by clock enable");
      wr(0, RCTMR_CLEAR_OFS, 16'h0003);
      repeat (3) @(posedge ref_clk);
      chk_irq(1'b0, "after clear");
      wr(0, RCTMR_CTRL_OFS, 16'h0000);
      meas(0, 0);
      chk16(dv, 16'h0000, "held while stopped");
      $display("test timer done");
   endtask : t_timer

   task automatic t_updown();
      wr(0, RCTMR_RELOAD_OFS, 16'h0010);
      wr(0, RCTMR_COUNT_OFS, 16'h0050);
      wr(0, RCTMR_CTRL_OFS, c_run | c_ud);
      meas(0, 0);
      chk16(dv, 16'd10, "up with pin high");
      trg_pin[0] <= 1'b0;
      repeat (4) @(posedge ref_clk);
      meas(0, 0);
      chk16(dv, 16'hFFF6, "down with pin low");
      wr(0, RCTMR_COUNT_OFS, 16'h0013);
      repeat (60) @(posedge ref_clk);
      rd(0, RCTMR_COUNT_OFS);
      chk16({rv[15:4], 4'h0}, 16'hFFF0, "underflow reload");
      chk_irq(1'b0, "no reload irq in up/down");
      $display("test updown done");
   endtask : t_updown

   task automatic t_capture();
      wr(0, RCTMR_CLEAR_OFS, 16'h0003);
      wr(0, RCTMR_COUNT_OFS, 16'hFFFE);
      wr(0, RCTMR_CTRL_OFS, c_run | c_cap | c_ris);
      wait_st(0, RCTMR_ST_RELOAD);
      chk_irq(1'b1, "capture-mode reload");
      rd(0, RCTMR_COUNT_OFS);
      chk16({rv[15:4], 4'h0}, RCTMR_ZERO, "reload to zero");
      wr(0, RCTMR_CLEAR_OFS, 16'h0003);
      wr(0, RCTMR_COUNT_OFS, 16'hABC0);
      trg_pin[0] <= 1'b1;
      wait_st(0, RCTMR_ST_CAPTURE);
      chk_irq(1'b1, "capture event");
      rd(0, RCTMR_RELOAD_OFS);
      chk16({rv[15:4], 4'h0}, 16'hABC0, "captured count");
      $display("test capture done");
   endtask : t_capture

   task automatic t_counter();
      wr(0, RCTMR_CTRL_OFS, 16'h0000);
      wr(0, RCTMR_CLEAR_OFS, 16'h0003);
      wr(1, RCTMR_COUNT_OFS, 16'h0000);
      wr(1, RCTMR_CTRL_OFS, c_cnt | c_run);
      repeat (30) @(posedge ref_clk);
      // second fall lands inside the hold-off window and must be lost
      cnt_pin[1] <= 1'b0;
      repeat (4) @(posedge ref_clk);
      cnt_pin[1] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      cnt_pin[1] <= 1'b0;
      repeat (30) @(posedge ref_clk);
      cnt_pin[1] <= 1'b1;
      repeat (30) @(posedge ref_clk);
      cnt_pin[1] <= 1'b0;
      repeat (30) @(posedge ref_clk);
      rd(1, RCTMR_COUNT_OFS);
      chk16(rv, 16'h0002, "falling edges counted");
      wr(1, RCTMR_RELOAD_OFS, 16'h0300);
      wr(1, RCTMR_ENABLE_OFS, 16'h0001);
      wr(1, RCTMR_CTRL_OFS, c_cnt | c_run | c_trg);
      trg_pin[1] <= 1'b0;
      wait_st(1, RCTMR_ST_RELOAD);
      rd(1, RCTMR_COUNT_OFS);
      chk16(rv, 16'h0300, "trigger-edge reload");
      chk_irq(1'b1, "instance 1 reload");
      wr(1, RCTMR_CLEAR_OFS, 16'h0003);
      repeat (3) @(posedge ref_clk);
      chk_irq(1'b0, "instance 1 cleared");
      $display("test counter done");
   endtask : t_counter

   // reset pulled in mid-run must clear the programmed state of an active instance
   task automatic t_reset();
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(1, RCTMR_RELOAD_OFS);
      chk16(rv, RCTMR_RESET_VAL, "reload after mid-run reset");
      rd(1, RCTMR_CTRL_OFS);
      chk16(rv, RCTMR_RESET_VAL, "ctrl after mid-run reset");
      chk_irq(1'b0, "after mid-run reset");
      $display("test reset done");
   endtask : t_reset

   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_regs();
      t_timer();
      t_updown();
      t_capture();
      t_counter();
      t_reset();
      tally_and_finish();
   end
endmodule : rctmr_timer_bench
`default_nettype wire
